// *** include/fsw_params.svh ***
// Constants of the flash status and write-protect block.
// Assumes a 50 MHz system clock and a single-line serial command link.
`ifndef FSW_PARAMS_SVH
`define FSW_PARAMS_SVH

// ----------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------
`define FSW_OP_WREN 8'h06
`define FSW_OP_WRDI 8'h04
`define FSW_OP_RDSR 8'h05
`define FSW_OP_WRSR 8'h01
`define FSW_OP_RDFLAG 8'h70
`define FSW_OP_CLFLAG 8'h50
`define FSW_OP_PROG 8'h02
`define FSW_OP_SE64 8'hD8
`define FSW_OP_SE32 8'h52
`define FSW_OP_SE4 8'h20
`define FSW_OP_BULK 8'hC7
`define FSW_OP_WRNVCFG 8'hB1

// ----------------------------------------------------------------
// Status and flag bit positions
// ----------------------------------------------------------------
`define FSW_SR_SRWD 7
`define FSW_SR_BP3 6
`define FSW_SR_TB 5
`define FSW_SR_BP2 4
`define FSW_SR_BP0 2
`define FSW_SR_WEL 1
`define FSW_SR_WIP 0
`define FSW_FL_READY 7
`define FSW_FL_ERASE 5
`define FSW_FL_PROG 4
`define FSW_FL_PROT 1

// ----------------------------------------------------------------
// Reset values and geometry
// ----------------------------------------------------------------
`define FSW_NV_RESET 6'h00
`define FSW_SECTOR_COUNT 9'h100
`define FSW_BP_ALL 4'h9

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FSW_SYS_CLK_MHZ 50
`define FSW_WRSR_TIME_NS 2000
`define FSW_WRSR_CYCLES ((`FSW_WRSR_TIME_NS * `FSW_SYS_CLK_MHZ + 999) / 1000)

`endif

// *** include/fsw_pkg.sv ***
// Types of the flash status and write-protect block.
// Assumes fsw_params.svh supplies all numeric constants.
package fsw_pkg;

    // Command execution states
    typedef enum logic [1:0] {
        FSW_ST_IDLE = 2'b00,
        FSW_ST_WAIT_CS = 2'b01,
        FSW_ST_WRSR = 2'b10,
        FSW_ST_ARRAY = 2'b11
    } fsw_state_type;

    // Operations handed to the array engine
    typedef enum logic [2:0] {
        FSW_ARR_PROG = 3'b000,
        FSW_ARR_SE64 = 3'b001,
        FSW_ARR_SE32 = 3'b010,
        FSW_ARR_SE4 = 3'b011,
        FSW_ARR_BULK = 3'b100,
        FSW_ARR_NVCFG = 3'b101
    } fsw_arr_op_type;

endpackage : fsw_pkg

// *** rtl/fsw_sync2.sv ***
// Two-stage level synchroniser with clock enable.
// Assumes d comes from another clock domain or a pin.
module fsw_sync2 #(
    parameter logic INIT = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic d,
    output logic q
);
    logic meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= INIT;
            q <= INIT;
        end else if (clk_en) begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule : fsw_sync2

// *** rtl/fsw_protect_decode.sv ***
// Decodes block-protect and top/bottom bits into a per-sector verdict.
// Assumes 256 uniform 64KB sectors addressed by address bits 23:16.
`include "fsw_params.svh"
module fsw_protect_decode
    import fsw_pkg::*;
(
    input wire logic [3:0] block_protect_field,
    input wire logic top_bottom,
    input wire logic [7:0] sector,
    output logic sector_protected,
    output logic any_protect
);
    logic [8:0] prot_count;
    logic [8:0] low_bound;

    // Size of the guarded region in sectors
    always_comb begin
        if (block_protect_field == 4'h0) begin
            prot_count = 9'h000;
        end else if (block_protect_field >= `FSW_BP_ALL) begin
            prot_count = `FSW_SECTOR_COUNT;
        end else begin
            prot_count = 9'h001 << (block_protect_field - 4'h1);
        end
    end

    // Region grows down from the top or up from sector zero
    always_comb begin
        low_bound = `FSW_SECTOR_COUNT - prot_count;
        any_protect = |block_protect_field;
        if (top_bottom) begin
            sector_protected = {1'b0, sector} < prot_count;
        end else begin
            sector_protected = any_protect && ({1'b0, sector} >= low_bound);
        end
    end

endmodule : fsw_protect_decode

// *** rtl/fsw_status_protect.sv ***
// Status register, flag status and write-protection logic of a serial flash.
// Assumes a single-line serial host, an array engine on sys_clk, and
// that the serial clock stands still while the chip select is high.
//
// What this block does
// [RULE1] The status register is read with read-status and written with write-status.
// [RULE2] With bit 7 set and the protect pin low, write-status is not executed.
// [RULE3] Only a high protect pin leaves the hardware-protected state; the code also leaves it while four_line_protocol is set.
// [RULE4] Bit 7 is the nonvolatile status-write disable, zero by default.
// [RULE5] Bit 5 places the guarded region at the top (0) or bottom (1).
// [RULE6] Block-protect bits 6 and 4:2 guard a region against program and erase.
// [RULE7] Bulk erase runs only when every block-protect bit is zero.
// [RULE8] The write enable latch at bit 1 is cleared at power-up.
// [RULE9] Write-enable sets the latch, and modifying commands need it set.
// [RULE10] Bit 0 reads one while a write, program or erase cycle runs.
// [RULE11] Bit 0 is always the inverse of flag status bit 7.
// [RULE12] Addresses are 24-bit bytes, with sectors of 64KB, 32KB and 4KB.
// [RULE13] Flag bit 7 reads zero while busy and one when ready.
// [RULE14] A hit on a guarded sector sets the protection error, not the array.
// [RULE15] In four-line protocol the protect pin is data line two, host driven.
// [RULE16] The latch clears when a write-status, program or erase ends.
// [RULE17] Write-status changes only nonvolatile bits, never latch or busy.
`include "fsw_params.svh"
module fsw_status_protect
    import fsw_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic io_line_two_in,
    output logic io_line_two_out,
    output logic io_line_two_oe,
    input wire logic four_line_protocol,
    output logic array_req,
    output logic [2:0] array_op,
    output logic [23:0] array_addr,
    input wire logic array_done,
    output logic [7:0] status_out,
    output logic [7:0] flag_out
);

    // ----------------------------------------------------------------
    // Link-side declarations
    // ----------------------------------------------------------------
    logic [2:0] bit_cnt_reg;
    logic [2:0] byte_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] opcode_reg;
    logic [7:0] data_reg;
    logic [23:0] addr_reg;
    logic cmd_tgl_reg;
    logic req_meta_reg;
    logic req_sync_reg;
    logic ack_reg;
    logic [15:0] link_snap_reg;
    logic [7:0] in_byte;
    logic [7:0] cur_op;
    logic [2:0] need_bytes;
    logic byte_end;
    logic is_read_op;
    logic [7:0] read_byte;

    // ----------------------------------------------------------------
    // System-side declarations
    // ----------------------------------------------------------------
    fsw_state_type state_reg;
    fsw_state_type state_next;
    logic cs_n_sync;
    logic wp_sync;
    logic cmd_tgl_sync;
    logic cmd_tgl_prev_reg;
    logic ack_sync;
    logic [7:0] pend_op_reg;
    logic [7:0] pend_data_reg;
    logic [23:0] pend_addr_reg;
    logic srwd_reg;
    logic tb_reg;
    logic [3:0] block_protect_field;
    logic wel_reg;
    logic wip_reg;
    logic prot_err_reg;
    logic prog_err_reg;
    logic erase_err_reg;
    logic [6:0] wrsr_cnt_reg;
    logic snap_req_reg;
    logic [15:0] snap_data_reg;
    logic [7:0] live_status;
    logic [7:0] live_flag;
    logic cmd_arrived;
    logic exec_now;
    logic hw_locked;
    logic is_erase;
    logic array_cmd;
    logic array_blocked;
    logic start_wrsr;
    logic start_array;
    logic prot_hit;
    logic wrsr_done;
    logic arr_done;
    logic sector_protected;
    logic any_protect;

    // ----------------------------------------------------------------
    // Link side: command reception on the serial clock
    // ----------------------------------------------------------------

    // Byte under assembly and opcode in force for this byte
    assign in_byte = {shift_reg[6:0], spi_mosi};
    assign cur_op = (byte_cnt_reg == 3'h0) ? in_byte : opcode_reg;
    assign byte_end = (bit_cnt_reg == 3'h7);

    // Bytes a command needs before it is handed over, zero for reads
    always_comb begin
        unique case (cur_op)
            `FSW_OP_WREN, `FSW_OP_WRDI, `FSW_OP_CLFLAG: need_bytes = 3'h1;
            `FSW_OP_BULK, `FSW_OP_WRNVCFG: need_bytes = 3'h1;
            `FSW_OP_WRSR: need_bytes = 3'h2;
            `FSW_OP_PROG, `FSW_OP_SE64, `FSW_OP_SE32, `FSW_OP_SE4: need_bytes = 3'h4;
            default: need_bytes = 3'h0;
        endcase
    end

    // Bit and byte counters restart with every frame
    always_ff @(posedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg <= in_byte;
            if (byte_end && byte_cnt_reg != 3'h7) begin
                byte_cnt_reg <= byte_cnt_reg + 3'h1;
            end
        end
    end

    // [RULE12] Capture opcode, data byte and 24-bit byte address
    always_ff @(posedge spi_sck or posedge rst) begin
        if (rst) begin
            opcode_reg <= 8'h00;
            data_reg <= 8'h00;
            addr_reg <= 24'h000000;
        end else if (!spi_cs_n && byte_end) begin
            unique case (byte_cnt_reg)
                3'h0: opcode_reg <= in_byte;
                3'h1: begin
                    data_reg <= in_byte;
                    addr_reg[23:16] <= in_byte;
                end
                3'h2: addr_reg[15:8] <= in_byte;
                3'h3: addr_reg[7:0] <= in_byte;
                default: data_reg <= data_reg;
            endcase
        end
    end

    // Command hand-over toggle, once the needed bytes are in
    always_ff @(posedge spi_sck or posedge rst) begin
        if (rst) begin
            cmd_tgl_reg <= 1'b0;
        end else if (!spi_cs_n && byte_end && need_bytes != 3'h0
                     && byte_cnt_reg == need_bytes - 3'h1) begin
            cmd_tgl_reg <= ~cmd_tgl_reg;
        end
    end

    // Snapshot handshake receiver: copy status words on a new request
    always_ff @(posedge spi_sck or posedge rst) begin
        if (rst) begin
            req_meta_reg <= 1'b0;
            req_sync_reg <= 1'b0;
            ack_reg <= 1'b0;
            link_snap_reg <= 16'h0080;
        end else begin
            req_meta_reg <= snap_req_reg;
            req_sync_reg <= req_meta_reg;
            if (req_sync_reg != ack_reg) begin
                link_snap_reg <= snap_data_reg;
                ack_reg <= req_sync_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // Link side: read-out on the falling serial clock edge
    // ----------------------------------------------------------------
    assign is_read_op = (opcode_reg == `FSW_OP_RDSR) || (opcode_reg == `FSW_OP_RDFLAG);
    assign read_byte = (opcode_reg == `FSW_OP_RDSR) ? link_snap_reg[15:8] : link_snap_reg[7:0];

    // [RULE1] Status byte repeats, most significant bit first
    always_ff @(negedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            spi_miso <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else if (byte_cnt_reg != 3'h0 && is_read_op) begin
            spi_miso <= read_byte[~bit_cnt_reg];
            spi_miso_oe <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // System side: synchronisers
    // ----------------------------------------------------------------
    fsw_sync2 #(.INIT(1'b1)) u_cs_sync (
        .clk(sys_clk), .rst(rst), .clk_en(clk_en), .d(spi_cs_n), .q(cs_n_sync)
    );
    fsw_sync2 #(.INIT(1'b1)) u_wp_sync (
        .clk(sys_clk), .rst(rst), .clk_en(clk_en), .d(io_line_two_in), .q(wp_sync)
    );
    fsw_sync2 u_cmd_sync (
        .clk(sys_clk), .rst(rst), .clk_en(clk_en), .d(cmd_tgl_reg), .q(cmd_tgl_sync)
    );
    fsw_sync2 u_ack_sync (
        .clk(sys_clk), .rst(rst), .clk_en(clk_en), .d(ack_reg), .q(ack_sync)
    );

    // ----------------------------------------------------------------
    // System side: decisions
    // ----------------------------------------------------------------
    fsw_protect_decode u_protect (
        .block_protect_field(block_protect_field),
        .top_bottom(tb_reg),
        .sector(pend_addr_reg[23:16]),
        .sector_protected(sector_protected),
        .any_protect(any_protect)
    );

    assign cmd_arrived = (cmd_tgl_sync != cmd_tgl_prev_reg);
    assign exec_now = (state_reg == FSW_ST_WAIT_CS) && cs_n_sync;
    // [RULE2] [RULE3] Locked while disable bit set and pin low
    // [RULE15] In four-line protocol the pin carries data, not protection
    assign hw_locked = srwd_reg && !wp_sync && !four_line_protocol;
    assign is_erase = (pend_op_reg == `FSW_OP_SE64) || (pend_op_reg == `FSW_OP_SE32)
                      || (pend_op_reg == `FSW_OP_SE4) || (pend_op_reg == `FSW_OP_BULK);
    assign array_cmd = is_erase || (pend_op_reg == `FSW_OP_PROG)
                       || (pend_op_reg == `FSW_OP_WRNVCFG);
    // [RULE6] [RULE7] Guarded sector or bulk erase with any protect bit
    assign array_blocked = (pend_op_reg == `FSW_OP_BULK) ? any_protect
                         : (pend_op_reg != `FSW_OP_WRNVCFG) && sector_protected;
    // [RULE9] Modifying commands only with the latch set
    assign start_wrsr = exec_now && (pend_op_reg == `FSW_OP_WRSR) && wel_reg && !hw_locked;
    assign start_array = exec_now && array_cmd && wel_reg && !array_blocked;
    assign prot_hit = exec_now && array_cmd && wel_reg && array_blocked;
    assign wrsr_done = (state_reg == FSW_ST_WRSR) && (wrsr_cnt_reg == 7'h00);
    assign arr_done = (state_reg == FSW_ST_ARRAY) && array_done;

    // ----------------------------------------------------------------
    // System side: command state machine
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            FSW_ST_IDLE: if (cmd_arrived) state_next = FSW_ST_WAIT_CS;
            FSW_ST_WAIT_CS: begin
                if (start_wrsr) begin
                    state_next = FSW_ST_WRSR;
                end else if (start_array) begin
                    state_next = FSW_ST_ARRAY;
                end else if (cs_n_sync) begin
                    state_next = FSW_ST_IDLE;
                end
            end
            FSW_ST_WRSR: if (wrsr_done) state_next = FSW_ST_IDLE;
            FSW_ST_ARRAY: if (arr_done) state_next = FSW_ST_IDLE;
        endcase
    end

    // State register and hand-over edge detector
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= FSW_ST_IDLE;
            cmd_tgl_prev_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            cmd_tgl_prev_reg <= cmd_tgl_sync;
        end
    end

    // Pending command words, stable on the link side until the next frame
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pend_op_reg <= 8'h00;
            pend_data_reg <= 8'h00;
            pend_addr_reg <= 24'h000000;
        end else if (clk_en && cmd_arrived && state_reg == FSW_ST_IDLE) begin
            pend_op_reg <= opcode_reg;
            pend_data_reg <= data_reg;
            pend_addr_reg <= addr_reg;
        end
    end

    // Write-status cycle timer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wrsr_cnt_reg <= 7'h00;
        end else if (clk_en) begin
            if (start_wrsr) begin
                wrsr_cnt_reg <= 7'(`FSW_WRSR_CYCLES - 1);
            end else if (wrsr_cnt_reg != 7'h00) begin
                wrsr_cnt_reg <= wrsr_cnt_reg - 7'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // System side: register bits
    // ----------------------------------------------------------------

    // [RULE4] [RULE5] [RULE17] Nonvolatile bits load only at write-status end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            {srwd_reg, block_protect_field[3], tb_reg, block_protect_field[2:0]} <= `FSW_NV_RESET;
        end else if (clk_en && wrsr_done) begin
            srwd_reg <= pend_data_reg[`FSW_SR_SRWD];
            tb_reg <= pend_data_reg[`FSW_SR_TB];
            block_protect_field[3] <= pend_data_reg[`FSW_SR_BP3];
            block_protect_field[2:0] <= pend_data_reg[`FSW_SR_BP2:`FSW_SR_BP0];
        end
    end

    // [RULE8] Latch cleared at reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wel_reg <= 1'b0;
        end else if (clk_en) begin
            // [RULE16] Latch drops when a modifying cycle ends or an array command is refused
            if (wrsr_done || arr_done || prot_hit) begin
                wel_reg <= 1'b0;
            // [RULE9] Write-enable sets the latch
            end else if (exec_now && pend_op_reg == `FSW_OP_WREN) begin
                wel_reg <= 1'b1;
            end else if (exec_now && pend_op_reg == `FSW_OP_WRDI) begin
                wel_reg <= 1'b0;
            end
        end
    end

    // [RULE10] Busy from cycle start to cycle end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wip_reg <= 1'b0;
        end else if (clk_en) begin
            if (start_wrsr || start_array) begin
                wip_reg <= 1'b1;
            end else if (wrsr_done || arr_done) begin
                wip_reg <= 1'b0;
            end
        end
    end

    // [RULE14] Error flags; a new hit wins over the clear command
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prot_err_reg <= 1'b0;
            prog_err_reg <= 1'b0;
            erase_err_reg <= 1'b0;
        end else if (clk_en) begin
            if (prot_hit) begin
                prot_err_reg <= 1'b1;
                prog_err_reg <= prog_err_reg || !is_erase;
                erase_err_reg <= erase_err_reg || is_erase;
            end else if (exec_now && pend_op_reg == `FSW_OP_CLFLAG) begin
                prot_err_reg <= 1'b0;
                prog_err_reg <= 1'b0;
                erase_err_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // System side: array engine requests
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            array_req <= 1'b0;
            array_op <= FSW_ARR_PROG;
            array_addr <= 24'h000000;
        end else if (clk_en) begin
            array_req <= start_array;
            if (start_array) begin
                array_addr <= pend_addr_reg;
                unique case (pend_op_reg)
                    `FSW_OP_SE64: array_op <= FSW_ARR_SE64;
                    `FSW_OP_SE32: array_op <= FSW_ARR_SE32;
                    `FSW_OP_SE4: array_op <= FSW_ARR_SE4;
                    `FSW_OP_BULK: array_op <= FSW_ARR_BULK;
                    `FSW_OP_WRNVCFG: array_op <= FSW_ARR_NVCFG;
                    default: array_op <= FSW_ARR_PROG;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // System side: visible status and snapshot to the link
    // ----------------------------------------------------------------
    // [RULE11] [RULE13] Ready bit and busy bit from one source
    always_comb begin
        live_status = {srwd_reg, block_protect_field[3], tb_reg,
                       block_protect_field[2:0], wel_reg, wip_reg};
        live_flag = 8'h00;
        live_flag[`FSW_FL_READY] = !wip_reg;
        live_flag[`FSW_FL_ERASE] = erase_err_reg;
        live_flag[`FSW_FL_PROG] = prog_err_reg;
        live_flag[`FSW_FL_PROT] = prot_err_reg;
    end

    // Registered copies for the rest of the chip
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status_out <= 8'h00;
            flag_out <= 8'h80;
        end else if (clk_en) begin
            status_out <= live_status;
            flag_out <= live_flag;
        end
    end

    // Snapshot sender: new words only once the last one was taken
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            snap_req_reg <= 1'b0;
            snap_data_reg <= 16'h0080;
        end else if (clk_en && ack_sync == snap_req_reg
                     && snap_data_reg != {live_status, live_flag}) begin
            snap_data_reg <= {live_status, live_flag};
            snap_req_reg <= ~snap_req_reg;
        end
    end

    // Data line two is only listened to by this block
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            io_line_two_out <= 1'b0;
            io_line_two_oe <= 1'b0;
        end else if (clk_en) begin
            io_line_two_out <= 1'b0;
            io_line_two_oe <= 1'b0;
        end
    end

endmodule : fsw_status_protect

// *** test/fsw_status_protect_asserts.sv ***
// Port checks of the status and write-protect block.
// Assumes clk_en is held high.
module fsw_status_protect_asserts (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic io_line_two_in,
    input wire logic four_line_protocol,
    input wire logic io_line_two_oe,
    input wire logic array_req,
    input wire logic [2:0] array_op,
    input wire logic array_done,
    input wire logic [7:0] status_out,
    input wire logic [7:0] flag_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    property p_rdy; status_out[0] != flag_out[7]; endproperty
    a_rdy: assert property (p_rdy) else $error("ready bit");
    property p_pin; !io_line_two_oe; endproperty
    a_pin: assert property (p_pin) else $error("pin driven");
    property p_busy; array_req |=> status_out[0] && !array_req; endproperty
    a_busy: assert property (p_busy) else $error("busy bit");
    property p_wel; array_req |-> status_out[1]; endproperty
    a_wel: assert property (p_wel) else $error("no latch");
    property p_bulk; array_req && array_op == 3'h4 |-> {status_out[6], status_out[4:2]} == 4'h0;
    endproperty
    a_bulk: assert property (p_bulk) else $error("bulk guarded");
    property p_end; array_done && status_out[0] |-> ##[1:3] status_out[1:0] == 2'h0; endproperty
    a_end: assert property (p_end) else $error("end state");
    property p_rst; $fell(rst) |-> status_out == 8'h00 && flag_out == 8'h80; endproperty
    a_rst: assert property (p_rst) else $error("reset value");
    property p_lock; !io_line_two_in [*4] ##0 (status_out[7] && !four_line_protocol)
        |=> $stable(status_out[7:2]); endproperty
    a_lock: assert property (p_lock) else $error("locked bits");
endmodule : fsw_status_protect_asserts

// *** test/fsw_host_model.sv ***
// Serial host that frames commands.
// Assumes link clock stands still while deselected.
module fsw_host_model (
    output logic spi_sck,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    task automatic frame(input logic [31:0] d, input int nb, output logic [7:0] rx);
        #7 spi_cs_n = 1'b0;
        for (int i = 8 * nb - 1; i >= 0; i--) begin
            spi_mosi = d[i];
            #16 spi_sck = 1'b1;
            rx = {rx[6:0], spi_miso};
            #16 spi_sck = 1'b0;
        end
        #16 spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        #90;
    endtask : frame
endmodule : fsw_host_model

// *** test/test_flash_status_write_protect.sv ***
// Bench of the status block; plays the array engine.
// Assumes the host model owns the serial link.
module test_flash_status_write_protect;
    timeunit 1ns;
    timeprecision 1ns;
    logic q4 = 1'b0;
    logic sys_clk = 1'b0, rst = 1'b1, wp = 1'b1, done = 1'b0, req, sck, cs_n, mosi, miso;
    logic [7:0] st, fl, rx, v, ef;
    logic [2:0] op, lop;
    logic [23:0] addr, a, la;
    logic [3:0] bc = 4'h0;
    int miscompares = 0, checks_done = 0, seed = 23624, nreq = 0, en = 0, j;
    logic [7:0] opc[6] = '{8'hD8, 8'h52, 8'h20, 8'h02, 8'hC7, 8'hB1};
    logic [2:0] opn[6] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h4, 3'h5};
    always #10 sys_clk = ~sys_clk;
    fsw_host_model host (.spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso));
    fsw_status_protect uut (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .spi_sck(sck),
        .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(),
        .io_line_two_in(wp), .io_line_two_out(), .io_line_two_oe(),
        .four_line_protocol(q4), .array_req(req), .array_op(op), .array_addr(addr),
        .array_done(done), .status_out(st), .flag_out(fl));
    // Array engine with a random busy time
    always @(negedge sys_clk) begin
        done <= (bc == 4'h1);
        bc <= req ? 4'h3 + 4'($random(seed) & 7) : bc - 4'(bc != 4'h0);
        nreq <= nreq + int'(req);
        la <= req ? addr : la;
        if (req)
            lop <= op;
    end
    // Guarded sector or guarded bulk
    function automatic logic hit(input logic [7:0] s, input logic [7:0] sec, input int j);
        int n;
        n = {s[6], s[4:2]};
        n = n == 0 ? 0 : n > 8 ? 256 : 1 << (n - 1);
        if (j > 3)
            return j == 4 && n != 0;
        return s[5] ? sec < n : sec >= 256 - n;
    endfunction : hit
    task automatic summarize();
        if (miscompares == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Frame, then bounded wait for ready
    task automatic cmd(input logic [31:0] d, input int nb);
        host.frame(d, nb, rx);
        repeat (6) @(negedge sys_clk);
        for (int i = 0; st[0] !== 1'b0; i++) begin
            if (i > 500) begin
                miscompares++;
                summarize();
            end
            @(negedge sys_clk);
        end
    endtask : cmd
    task automatic rd(input logic [7:0] exp);
        host.frame(32'h0500, 2, rx);
        chk(rx, exp);
    endtask : rd
    task automatic wrsr(input logic [7:0] d);
        cmd(32'h06, 1);
        cmd({16'h0, 8'h01, d}, 2);
    endtask : wrsr
    initial begin
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk(fl, 8'h80);
        cmd(32'h017C, 2);
        rd(8'h00);
        cmd(32'h06, 1);
        rd(8'h02);
        cmd(32'h04, 1);
        rd(8'h00);
        // Random settings against every array command
        for (int k = 0; k < 18; k++) begin
            j = k % 6;
            v = k == 4 ? 8'h20 : 8'($random(seed)) & 8'hFC;
            a = k == 0 ? 24'hFF0000 : 24'($random(seed));
            wrsr(v);
            rd(v);
            cmd(32'h06, 1);
            cmd(j > 3 ? 32'(opc[j]) : {opc[j], a}, j > 3 ? 1 : 4);
            ef = hit(v, a[23:16], j) ? (j == 3 ? 8'h92 : 8'hA2) : 8'h80;
            en += int'(ef == 8'h80);
            chk(fl, ef);
            host.frame(32'h7000, 2, rx);
            chk(rx, ef);
            chk(8'(nreq), 8'(en));
            if (ef == 8'h80)
                chk({la != a && j < 4, 4'h0, lop}, {5'h0, opn[j]});
            rd(v);
            cmd(32'h50, 1);
        end
        wrsr(8'h80);
        wp = 1'b0;
        wrsr(8'h00);
        rd(8'h82);
        q4 = 1'b1;
        cmd(32'h01A0, 2);
        rd(8'hA0);
        q4 = 1'b0;
        wp = 1'b1;
        wrsr(8'h00);
        rd(8'h00);
        summarize();
    end
endmodule : test_flash_status_write_protect
bind fsw_status_protect fsw_status_protect_asserts chk_i (.sys_clk(sys_clk), .rst(rst),
    .io_line_two_in(io_line_two_in), .four_line_protocol(four_line_protocol),
    .io_line_two_oe(io_line_two_oe), .array_req(array_req), .array_op(array_op),
    .array_done(array_done), .status_out(status_out), .flag_out(flag_out));
